// >>> hw/rwp_pkg.sv
package rwp_pkg;

    // clock and timing
    localparam int REF_CLK_HZ = 50_000_000;
    localparam int CORE_CLK_HZ = 25_000_000;
    localparam int WAKE_MIN_CORE_CYCLES = 2;
    // wake request must stay low longer than 2 core periods; counted on the 50 MHz clock
    localparam int WAKE_HOLD_CYCLES = (WAKE_MIN_CORE_CYCLES * REF_CLK_HZ + CORE_CLK_HZ - 1) / CORE_CLK_HZ;
    // internal power-on reset stretch after the pin releases
    localparam int POR_STRETCH_CYCLES = 16;

    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] WAKE_HOLD_CNT = CNT_W'(WAKE_HOLD_CYCLES);
    localparam logic [CNT_W-1:0] POR_STRETCH_CNT = CNT_W'(POR_STRETCH_CYCLES);

    // reset values
    localparam logic [1:0] SYNC_RST = 2'h0;
    localparam logic [1:0] SYNC_IDLE_HIGH = 2'h3;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

    typedef enum logic [1:0] {
        RWP_ST_RESET = 2'b00,
        RWP_ST_STRETCH = 2'b01,
        RWP_ST_LOAD = 2'b10,
        RWP_ST_RUN = 2'b11
    } rwp_state_t;

    // software-side view of one general purpose pin
    typedef struct packed {
        logic out_val;
        logic out_en;
    } rwp_gpio_ctl_t;

    // pin driver signals of one general purpose pin
    typedef struct packed {
        logic o;
        logic oe;
    } rwp_gpio_pad_t;

    typedef struct packed {
        rwp_state_t state;
        logic [1:0] rst_sync;
        logic [1:0] wake_sync;
        logic [1:0] gp1_sync;
        logic [1:0] gp2_sync;
        logic [CNT_W-1:0] por_cnt;
        logic [CNT_W-1:0] wake_cnt;
        logic wake_seen;
        logic sys_rst;
        logic load_start;
        logic wake_event;
        logic network_wake_ready;
        logic gp1_in;
        logic gp2_in;
        rwp_gpio_pad_t gp1_pad;
        rwp_gpio_pad_t gp2_pad;
    } rwp_regs_t;

endpackage

// >>> hw/rwp_reset_wake_pin_control.sv
`timescale 1ns/10ps
// Contract
// RL1 - low chip reset pin resets everything; here wake filter, pin inputs and NETWORK_WAKE_READY keep state
// RL2 - pin feeds internal power-on reset generator
// RL3 - configuration load starts automatically after reset
// RL4 - wake source holds pin low over two periods
// RL5 - wake recognised only after sustained low
// RL6 - pin one is input after reset
// RL7 - pin one level sets wake-ready default
// RL8 - pin two usable as input or output
// RL9 - synchronise async pins, release reset synchronously
module rwp_reset_wake_pin_control (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic RESET_LOW,
    input wire logic EXT_WAKE_REQUEST_LOW,
    input wire logic LOAD_DONE,
    input wire logic GPIO1_I,
    input wire logic GPIO2_I,
    input wire rwp_pkg::rwp_gpio_ctl_t GPIO1_CTL,
    input wire rwp_pkg::rwp_gpio_ctl_t GPIO2_CTL,
    output logic SYS_RST,
    output logic LOAD_START,
    output logic WAKE_EVENT,
    output logic NETWORK_WAKE_READY,
    output logic GPIO1_IN,
    output logic GPIO2_IN,
    output logic GPIO1_O,
    output logic GPIO1_OE,
    output logic GPIO2_O,
    output logic GPIO2_OE
);
    import rwp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registered state and its next value
    rwp_regs_t r_reg;
    rwp_regs_t r_next;

    ////////////////////////////////////////////////////////////////////////////
    // decoded views of the registered state
    logic chip_pin_released;
    logic wake_pin_low;
    logic stretch_done;
    logic wake_held;
    logic wake_allowed;
    logic ready_level;
    logic [CNT_W-1:0] por_cnt_inc;
    logic [CNT_W-1:0] wake_cnt_inc;

    // pad requests from the software side
    rwp_gpio_pad_t gp1_drive;
    rwp_gpio_pad_t gp2_drive;

    // pin levels are only read from the second synchroniser stage
    assign chip_pin_released = r_reg.rst_sync[1]; // RL9
    assign wake_pin_low = !r_reg.wake_sync[1]; // RL9
    assign ready_level = r_reg.gp1_sync[1]; // RL7

    // counter steps and their end points
    assign por_cnt_inc = r_reg.por_cnt + 8'h01;
    assign wake_cnt_inc = r_reg.wake_cnt + 8'h01;
    assign stretch_done = (r_reg.por_cnt == POR_STRETCH_CNT - 8'h01);
    assign wake_held = (r_reg.wake_cnt >= WAKE_HOLD_CNT);

    // only one event per low period, none while the main reset is up
    assign wake_allowed = !r_reg.wake_seen && !r_reg.sys_rst;

    // software drive request of each general purpose pin
    assign gp1_drive = {GPIO1_CTL.out_val, GPIO1_CTL.out_en};
    assign gp2_drive = {GPIO2_CTL.out_val, GPIO2_CTL.out_en};

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        r_next = r_reg;

        // shift each pin through its two-stage synchroniser
        r_next.rst_sync = {r_reg.rst_sync[0], RESET_LOW}; // RL9
        r_next.wake_sync = {r_reg.wake_sync[0], EXT_WAKE_REQUEST_LOW}; // RL9
        r_next.gp1_sync = {r_reg.gp1_sync[0], GPIO1_I};
        r_next.gp2_sync = {r_reg.gp2_sync[0], GPIO2_I};

        // the start and wake strobes last one cycle
        r_next.load_start = 1'b0;
        r_next.wake_event = 1'b0;

        // power-on reset sequencer
        unique case (r_reg.state)
            RWP_ST_RESET: begin
                // main reset held while the chip reset pin is low
                r_next.sys_rst = 1'b1;
                r_next.por_cnt = CNT_RST;
                if (chip_pin_released) begin
                    r_next.state = RWP_ST_STRETCH; // RL2
                end else begin
                    r_next.state = RWP_ST_RESET;
                end
            end

            RWP_ST_STRETCH: begin
                // main reset stays up for the whole stretch
                r_next.sys_rst = 1'b1;
                r_next.por_cnt = por_cnt_inc;
                if (stretch_done) begin
                    r_next.sys_rst = 1'b0; // RL9
                    r_next.load_start = 1'b1; // RL3
                    r_next.network_wake_ready = ready_level; // RL7
                    r_next.state = RWP_ST_LOAD;
                end else begin
                    r_next.state = RWP_ST_STRETCH;
                end
            end

            RWP_ST_LOAD: begin
                // wait for the configuration loader to finish
                r_next.sys_rst = 1'b0;
                if (LOAD_DONE) begin
                    r_next.state = RWP_ST_RUN;
                end else begin
                    r_next.state = RWP_ST_LOAD;
                end
            end

            RWP_ST_RUN: begin
                // normal operation until the chip reset pin falls
                r_next.sys_rst = 1'b0;
                r_next.state = RWP_ST_RUN;
            end
        endcase

        // wake filter: the low level must outlast the minimum hold
        if (!wake_pin_low) begin
            // a high pin restarts the filter
            r_next.wake_cnt = CNT_RST;
            r_next.wake_seen = 1'b0;
        end else if (!wake_held) begin
            // count cycles of sustained low
            r_next.wake_cnt = wake_cnt_inc;
        end else if (wake_allowed) begin
            // hold time exceeded: report once
            r_next.wake_event = 1'b1; // RL5
            r_next.wake_seen = 1'b1;
        end else begin
            // counter rests at its limit until the pin rises
            r_next.wake_cnt = r_reg.wake_cnt;
        end

        // synchronised pin levels for the software side
        r_next.gp1_in = r_reg.gp1_sync[1];
        r_next.gp2_in = r_reg.gp2_sync[1]; // RL8

        // pin one stays an input while the main reset is up
        if (r_reg.sys_rst) begin
            r_next.gp1_pad = '0; // RL6
        end else begin
            r_next.gp1_pad = gp1_drive;
        end

        // pin two follows software as input or output
        if (r_reg.sys_rst) begin
            r_next.gp2_pad = '0;
        end else begin
            r_next.gp2_pad = gp2_drive; // RL8
        end

        // a low chip reset pin overrides the whole sequence
        if (!chip_pin_released) begin
            r_next.state = RWP_ST_RESET; // RL1
            r_next.sys_rst = 1'b1;
            r_next.por_cnt = CNT_RST;
            r_next.load_start = 1'b0;
            r_next.gp1_pad = '0;
            r_next.gp2_pad = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register with synchronous reset
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            // everything clears, then the fields that rest elsewhere
            r_reg <= '0;
            r_reg.state <= RWP_ST_RESET;
            r_reg.sys_rst <= 1'b1;

            // chip pin counts as low until its synchroniser fills
            r_reg.rst_sync <= SYNC_RST;

            // wake pin rests high so no false wake follows reset
            r_reg.wake_sync <= SYNC_IDLE_HIGH;

            // general purpose pins and counters start from zero
            r_reg.gp1_sync <= SYNC_RST;
            r_reg.gp2_sync <= SYNC_RST;
            r_reg.por_cnt <= CNT_RST;
            r_reg.wake_cnt <= CNT_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset sequencer outputs straight from flops
    assign SYS_RST = r_reg.sys_rst;
    assign LOAD_START = r_reg.load_start;

    // wake outputs straight from flops
    assign WAKE_EVENT = r_reg.wake_event;
    assign NETWORK_WAKE_READY = r_reg.network_wake_ready;

    // synchronised pin levels
    assign GPIO1_IN = r_reg.gp1_in;
    assign GPIO2_IN = r_reg.gp2_in;

    // pin drivers, enable high while driving
    assign GPIO1_O = r_reg.gp1_pad.o;
    assign GPIO1_OE = r_reg.gp1_pad.oe;
    assign GPIO2_O = r_reg.gp2_pad.o;
    assign GPIO2_OE = r_reg.gp2_pad.oe;
endmodule

// >>> dv/rwp_props.sv
`timescale 1ns/10ps
module rwp_props (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic RESET_LOW,
    input wire logic EXT_WAKE_REQUEST_LOW,
    input wire logic GPIO1_I,
    input wire rwp_pkg::rwp_gpio_ctl_t GPIO1_CTL,
    input wire rwp_pkg::rwp_gpio_ctl_t GPIO2_CTL,
    input wire logic SYS_RST,
    input wire logic LOAD_START,
    input wire logic WAKE_EVENT,
    input wire logic NETWORK_WAKE_READY,
    input wire logic GPIO1_O,
    input wire logic GPIO1_OE,
    input wire logic GPIO2_O,
    input wire logic GPIO2_OE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // reset pin, stretch and load start
    property p_rst; !RESET_LOW [*4] |=> SYS_RST; endproperty
    a_rst: assert property (p_rst) else $error("chip reset ignored");
    property p_hold; !RESET_LOW [*4] ##1 RESET_LOW |-> SYS_RST [*8]; endproperty
    a_hold: assert property (p_hold) else $error("reset not stretched");
    property p_load; LOAD_START == $fell(SYS_RST); endproperty
    a_load: assert property (p_load) else $error("load start wrong");
    // wake filter
    property p_wmin;
        WAKE_EVENT |-> !$past(EXT_WAKE_REQUEST_LOW, 3) && !$past(EXT_WAKE_REQUEST_LOW, 4)
            && !$past(EXT_WAKE_REQUEST_LOW, 5) && !$past(EXT_WAKE_REQUEST_LOW, 6) && !$past(EXT_WAKE_REQUEST_LOW, 7);
    endproperty
    a_wmin: assert property (p_wmin) else $error("wake too early");
    property p_wfire; $fell(EXT_WAKE_REQUEST_LOW) ##1 (!EXT_WAKE_REQUEST_LOW && !SYS_RST) [*7] |-> ##[0:2] WAKE_EVENT;
    endproperty
    a_wfire: assert property (p_wfire) else $error("wake missed");
    // pins
    property p_oe; SYS_RST && $past(SYS_RST) |-> !GPIO1_OE && !GPIO2_OE; endproperty
    a_oe: assert property (p_oe) else $error("pin driven in reset");
    property p_gp2; !SYS_RST && $past(SYS_RST) == 0 |-> {GPIO2_O, GPIO2_OE} == $past(GPIO2_CTL); endproperty
    a_gp2: assert property (p_gp2) else $error("pin two drive wrong");
    property p_gp1; !SYS_RST && $past(SYS_RST) == 0 |-> {GPIO1_O, GPIO1_OE} == $past(GPIO1_CTL); endproperty
    a_gp1: assert property (p_gp1) else $error("pin one drive wrong");
    property p_ready; $fell(SYS_RST) |-> NETWORK_WAKE_READY == $past(GPIO1_I, 3); endproperty
    a_ready: assert property (p_ready) else $error("ready mode wrong");
    c_wake: cover property (WAKE_EVENT);
    c_load: cover property (LOAD_START);
    c_drive: cover property (GPIO2_OE);
endmodule
bind rwp_reset_wake_pin_control rwp_props props (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .RESET_LOW(RESET_LOW),
    .EXT_WAKE_REQUEST_LOW(EXT_WAKE_REQUEST_LOW),
    .GPIO1_I(GPIO1_I),
    .GPIO1_CTL(GPIO1_CTL),
    .GPIO2_CTL(GPIO2_CTL),
    .SYS_RST(SYS_RST),
    .LOAD_START(LOAD_START),
    .WAKE_EVENT(WAKE_EVENT),
    .NETWORK_WAKE_READY(NETWORK_WAKE_READY),
    .GPIO1_O(GPIO1_O),
    .GPIO1_OE(GPIO1_OE),
    .GPIO2_O(GPIO2_O),
    .GPIO2_OE(GPIO2_OE)
);

// >>> dv/rwp_board.sv
`timescale 1ns/10ps
module rwp_board (
    input wire logic ref_clk,
    output logic reset_low,
    output logic wake_low
);
    // both pins rest at their pull-up level
    initial begin
        reset_low = 1'b1;
        wake_low = 1'b1;
    end
    // chip reset held low for n cycles
    task automatic chip_reset(int n);
        reset_low = 1'b0;
        repeat (n) @(posedge ref_clk);
        #2 reset_low = 1'b1;
    endtask
    // wake request low for n cycles, short ones on purpose
    task automatic wake(int n);
        wake_low = 1'b0;
        repeat (n) @(posedge ref_clk);
        #2 wake_low = 1'b1;
    endtask
endmodule

// >>> dv/reset_wake_pin_control_test.sv
`timescale 1ns/10ps
module reset_wake_pin_control_test;
    import rwp_pkg::*;
    logic ref_clk = 0, rst = 1, load_done = 0, gpio1_i = 0, gpio2_i = 0, reset_low, wake_low;
    logic sys_rst, load_start, wake_event, ready, in1, in2, o1, oe1, o2, oe2;
    rwp_gpio_ctl_t ctl1 = '0, ctl2 = '0;
    logic [1:0] notes[$];
    logic [31:0] lfsr = 32'h2C6CBB6F;
    int errors = 0, tests_run = 0, n;
    always #10 ref_clk = ~ref_clk;
    rwp_board board (.ref_clk(ref_clk), .reset_low(reset_low), .wake_low(wake_low));
    rwp_reset_wake_pin_control dut (.REF_CLK(ref_clk), .RST(rst), .RESET_LOW(reset_low),
        .EXT_WAKE_REQUEST_LOW(wake_low), .LOAD_DONE(load_done), .GPIO1_I(gpio1_i), .GPIO2_I(gpio2_i),
        .GPIO1_CTL(ctl1), .GPIO2_CTL(ctl2), .SYS_RST(sys_rst), .LOAD_START(load_start),
        .WAKE_EVENT(wake_event), .NETWORK_WAKE_READY(ready), .GPIO1_IN(in1), .GPIO2_IN(in2),
        .GPIO1_O(o1), .GPIO1_OE(oe1), .GPIO2_O(o2), .GPIO2_OE(oe2));
    ////////////////////////////////////////////////////////////////////////////////
    // helpers: random source, compare, verdict, delay
    function automatic logic [31:0] step(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(logic [1:0] seen, logic [1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tick(int c);
        repeat (c) @(posedge ref_clk);
        #2;
    endtask
    // each pulse takes the oldest note: 2 is load start, 1 is wake
    always @(negedge ref_clk) begin
        if (load_start | wake_event) begin
            check({load_start, wake_event}, notes.size() ? notes.pop_front() : 2'h0);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // boots, wake pulses around the hold limit, random pin traffic
    initial begin
        notes.push_back(2'h2);
        tick(6);
        rst = 0;
        for (int r = 0; r < 3; r++) begin
            for (n = 0; n < 60 && sys_rst !== 1'b0; n++) tick(1);
            if (n == 60) begin
                errors++;
                give_verdict();
            end
            load_done = 1;
            tick(1);
            load_done = 0;
            check({1'b0, ready}, {1'b0, gpio1_i});
            for (int k = 0; k < 12; k++) begin
                lfsr = step(lfsr);
                ctl1 = lfsr[1:0];
                ctl2 = lfsr[3:2];
                gpio2_i = lfsr[4];
                n = lfsr[5] ? 1 + lfsr[7:6] : 5 + lfsr[9:7];
                if (n > WAKE_HOLD_CYCLES) notes.push_back(2'h1);
                board.wake(n);
                tick(3 + lfsr[11:10]);
                check({1'b0, in2}, {1'b0, gpio2_i});
                check({o1, oe1}, ctl1);
                check({o2, oe2}, ctl2);
            end
            gpio1_i = lfsr[12];
            notes.push_back(2'h2);
            board.chip_reset(4 + r);
        end
        tick(30);
        check({1'b0, notes.size() != 0}, 2'h0);
        give_verdict();
    end
endmodule
